// ==== rtl/crfs_top.sv ====
// Receive flag and bus state status register of a CAN controller
// Operation
// - Outside init mode, writing one clears a flag; writing zero leaves it.
// - A clear takes effect only when the setting condition has ceased.
// - While init request and ack are both one, flags are held reset.
// - Writes are accepted again once init request and ack are both zero.
// - Receiver state 5:4 and transmitter state 3:2 are read-only.
// - Init mode does not alter the receiver and transmitter state fields.
// - Bus activity in sleep with wake-on-activity enabled sets wake flag, bit 7.
// - Wake flag set and enabled keeps a wake interrupt asserted.
// - Bus state change sets bit 6; when enabled it raises error interrupt.
// - While bit 6 pends, state fields freeze until software clears it.
// - Receiver code: 00 to 96, 01 to 127, 10 above, 11 bus-off.
// - Bus-off shows in receiver state; leaving bus-off returns receiver to 00.
// - State fields show the transmitter state from the transmit counter.
// - Receive overrun sets bit 1; when enabled it raises error interrupt.
// - Shifting a message into the foreground buffer sets bit 0.
// - Only error-free, identifier- and CRC-matching messages are signalled.
// - While buffer-full is set, no further FIFO entry is shifted.
// - Buffer-full set and enabled asserts a receive interrupt.
// - Each flag is gated by its own bit in the enable register.
// - Sleep is active only when sleep request and ack are both one.
// - Sensitivity 00 none, 01 bus-off, 10 also error state, 11 all.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "crfs_defs.svh"

module crfs_top
  import crfs_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [`CRFS_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  // Mode handshakes from the controller
  input wire logic i_init_mode_request,
  input wire logic i_init_mode_ack,
  input wire logic i_sleep_request,
  input wire logic i_sleep_ack,
  input wire logic i_wake_on_activity_enable,
  // Bus and receive path events
  input wire logic i_bus_activity,
  input wire logic i_overrun,
  input wire crfs_cnt_s i_counts,
  input wire logic i_fifo_pending,
  output logic o_fifo_shift,
  // Interrupt requests
  output logic o_wake_irq,
  output logic o_err_irq,
  output logic o_rx_irq
);

  // ************************************************
  // Decoding
  // ************************************************
  logic init_active;
  logic writable;
  logic sleep_active;
  logic wr_flags;
  logic wr_enables;
  crfs_state_s live;
  crfs_state_s st_reg;
  crfs_state_s st_next;
  logic wake_reg;
  logic csc_reg;
  logic ovr_reg;
  logic rxf_reg;
  logic [7:0] en_reg;
  logic [7:0] flags_img;
  logic wake_evt;
  logic csc_evt;
  logic shift_cond;

  // Does a state change matter at the given sensitivity
  function automatic logic sens_hit(input logic [1:0] sel, input crfs_bus_e old_s, input crfs_bus_e new_s);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      2'h0: hit = 1'b0;
      2'h1: hit = (old_s != new_s) && (old_s == CRFS_BUSOFF || new_s == CRFS_BUSOFF);
      2'h2: hit = (old_s != new_s) && (old_s[1] || new_s[1]);
      2'h3: hit = (old_s != new_s);
    endcase
    return hit;
  endfunction

  // Mode qualifiers and write strobes
  assign init_active = i_init_mode_request && i_init_mode_ack;
  assign writable = !i_init_mode_request && !i_init_mode_ack;
  assign sleep_active = i_sleep_request && i_sleep_ack;
  assign wr_flags = i_wr && (i_addr == `CRFS_ADDR_FLAGS) && writable;
  assign wr_enables = i_wr && (i_addr == `CRFS_ADDR_ENABLES) && writable;

  // ************************************************
  // Bus state tracking
  // ************************************************
  crfs_state_enc u_state_enc (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_counts(i_counts),
    .o_live(live)
  );

  // Candidate display state; leaving bus-off drops the receiver to OK
  // The forced OK step makes the exit visible even when the counts land on a warning level
  always_comb begin
    st_next.tx = live.tx;
    st_next.rx = live.rx;
    if (st_reg.rx == CRFS_BUSOFF && live.rx != CRFS_BUSOFF) begin
      st_next.rx = CRFS_OK;
    end
  end

  // A relevant change is flagged only while no change is pending
  // Blocking further sets while pending keeps the frozen pair consistent with the flag
  assign csc_evt = !csc_reg && !init_active &&
                   (sens_hit(en_reg[`CRFS_RECEIVER_STATE_HI:`CRFS_RECEIVER_STATE_LO], st_reg.rx, st_next.rx) ||
                    sens_hit(en_reg[`CRFS_TRANSMITTER_STATE_HI:`CRFS_TRANSMITTER_STATE_LO], st_reg.tx, st_next.tx));

  // Display state: software cannot write it and init does not touch it
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_reg <= '{rx: CRFS_OK, tx: CRFS_OK};
    end else if (!csc_reg) begin
      st_reg <= st_next;
    end
  end

  // ************************************************
  // Flags
  // ************************************************
  assign wake_evt = i_bus_activity && sleep_active && i_wake_on_activity_enable;
  assign shift_cond = i_fifo_pending && !rxf_reg && !init_active;

  // Wake flag; the event wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || init_active) begin
      wake_reg <= 1'b0;
    end else if (wake_evt) begin
      wake_reg <= 1'b1;
    end else if (wr_flags && i_wr_data[`CRFS_BIT_WAKE]) begin
      wake_reg <= 1'b0;
    end
  end

  // Status change flag
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || init_active) begin
      csc_reg <= 1'b0;
    end else if (csc_evt) begin
      csc_reg <= 1'b1;
    end else if (wr_flags && i_wr_data[`CRFS_BIT_CSC]) begin
      csc_reg <= 1'b0;
    end
  end

  // Overrun flag
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || init_active) begin
      ovr_reg <= 1'b0;
    end else if (i_overrun) begin
      ovr_reg <= 1'b1;
    end else if (wr_flags && i_wr_data[`CRFS_BIT_OVR]) begin
      ovr_reg <= 1'b0;
    end
  end

  // Buffer-full flag; a clear releases the buffer and lets the next entry in
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || init_active) begin
      rxf_reg <= 1'b0;
    end else if (shift_cond) begin
      rxf_reg <= 1'b1;
    end else if (wr_flags && i_wr_data[`CRFS_BIT_RXF]) begin
      rxf_reg <= 1'b0;
    end
  end

  // Shift strobe toward the receive FIFO
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_fifo_shift <= 1'b0;
    end else begin
      o_fifo_shift <= shift_cond;
    end
  end

  // ************************************************
  // Enable register
  // ************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || init_active) begin
      en_reg <= `CRFS_ENABLES_RST;
    end else if (wr_enables) begin
      en_reg <= i_wr_data;
    end
  end

  // ************************************************
  // Interrupt requests
  // ************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_wake_irq <= 1'b0;
      o_err_irq <= 1'b0;
      o_rx_irq <= 1'b0;
    end else begin
      o_wake_irq <= wake_reg && en_reg[`CRFS_BIT_WAKE];
      o_err_irq <= (csc_reg && en_reg[`CRFS_BIT_CSC]) || (ovr_reg && en_reg[`CRFS_BIT_OVR]);
      o_rx_irq <= rxf_reg && en_reg[`CRFS_BIT_RXF];
    end
  end

  // ************************************************
  // Read port
  // ************************************************
  assign flags_img = {wake_reg, csc_reg, st_reg.rx, st_reg.tx, ovr_reg, rxf_reg};

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd && i_addr == `CRFS_ADDR_FLAGS) begin
      o_rd_data <= flags_img;
    end else if (i_rd && i_addr == `CRFS_ADDR_ENABLES) begin
      o_rd_data <= en_reg;
    end else begin
      o_rd_data <= 8'h00;
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  init_hold_a: assert property (init_active |=> !wake_reg && !csc_reg && !ovr_reg && !rxf_reg)
    else $error("flags not held clear in init mode");

  ovr_clear_a: assert property (wr_flags && i_wr_data[`CRFS_BIT_OVR] && !i_overrun && !init_active |=> !ovr_reg)
    else $error("overrun flag not cleared by write of one");

  zero_write_a: assert property (ovr_reg && !init_active && !(wr_flags && i_wr_data[`CRFS_BIT_OVR]) |=> ovr_reg)
    else $error("overrun flag lost without clear");

  set_wins_a: assert property (i_overrun && !init_active |=> ovr_reg)
    else $error("overrun event lost");

  wake_set_a: assert property (i_bus_activity && i_sleep_request && i_sleep_ack
                                && i_wake_on_activity_enable && !init_active |=> wake_reg)
    else $error("wake flag not set on activity in sleep");

  state_freeze_a: assert property (csc_reg ##1 csc_reg |-> $stable(st_reg))
    else $error("state fields moved while change pending");

  state_follow_a: assert property ($changed(st_reg) |-> !$past(csc_reg) && st_reg.tx == $past(live.tx))
    else $error("state field changed without counter cause");

  shift_block_a: assert property (rxf_reg |=> !o_fifo_shift)
    else $error("shift while buffer full");

  rxf_set_a: assert property (o_fifo_shift |-> rxf_reg && !$past(rxf_reg))
    else $error("shift did not set buffer full");

  rx_irq_a: assert property (rxf_reg && en_reg[`CRFS_BIT_RXF] |=> o_rx_irq)
    else $error("receive interrupt missing");

  err_irq_a: assert property (csc_reg && en_reg[`CRFS_BIT_CSC] |=> o_err_irq)
    else $error("error interrupt missing for status change");

  busoff_exit_a: assert property (st_reg.rx == CRFS_BUSOFF && !csc_reg && live.rx != CRFS_BUSOFF
                                  |=> st_reg.rx == CRFS_OK)
    else $error("receiver did not return to ok after bus-off");

  // ************************************************
  // Flag checks
  // ************************************************
  // Clears need a one, events beat clears, and a flag never drops on its own
  wake_clear_a: assert property (wr_flags && i_wr_data[`CRFS_BIT_WAKE] && !wake_evt |=> !wake_reg)
    else $error("wake flag not cleared by write of one");

  rxf_clear_a: assert property (wr_flags && i_wr_data[`CRFS_BIT_RXF] && !shift_cond |=> !rxf_reg)
    else $error("buffer full flag not cleared by write of one");

  rxf_hold_a: assert property (rxf_reg && !init_active && !(wr_flags && i_wr_data[`CRFS_BIT_RXF])
                               |=> rxf_reg)
    else $error("buffer full flag lost without clear");

  csc_hold_a: assert property (csc_reg && !init_active && !(wr_flags && i_wr_data[`CRFS_BIT_CSC])
                               |=> csc_reg)
    else $error("status change flag lost without clear");

  wake_sleep_a: assert property (!wake_reg && !sleep_active |=> !wake_reg)
    else $error("wake flag set outside sleep");

  shift_init_a: assert property (init_active |=> !o_fifo_shift)
    else $error("shift during init mode");

  // ************************************************
  // Bus state checks
  // ************************************************
  // The captured pair must be the one that raised the flag
  csc_capture_a: assert property (csc_evt |=> csc_reg && st_reg == $past(st_next))
    else $error("state pair not captured with status change");

  ro_fields_a: assert property (wr_flags && csc_reg |=> $stable(st_reg))
    else $error("write altered read-only state fields");

  csc_mute_a: assert property (en_reg[`CRFS_RECEIVER_STATE_HI:`CRFS_TRANSMITTER_STATE_LO] == 4'h0 && !csc_reg |=> !csc_reg)
    else $error("status change flagged with sensitivity off");

  rx_busoff_a: assert property (live.tx == CRFS_BUSOFF |-> live.rx == CRFS_BUSOFF)
    else $error("bus-off missing from receiver state");

  tx_code_a: assert property (32'(i_counts.tx_errors) > `CRFS_BUSOFF_LIMIT |=> live.tx == CRFS_BUSOFF)
    else $error("transmitter bus-off not classified");

  // ************************************************
  // Interrupt and enable checks
  // ************************************************
  // Every request follows its flag and its own enable bit
  wake_irq_a: assert property (wake_reg && en_reg[`CRFS_BIT_WAKE] |=> o_wake_irq)
    else $error("wake interrupt missing");

  ovr_irq_a: assert property (ovr_reg && en_reg[`CRFS_BIT_OVR] |=> o_err_irq)
    else $error("error interrupt missing for overrun");

  rx_gate_a: assert property (!en_reg[`CRFS_BIT_RXF] |=> !o_rx_irq)
    else $error("receive interrupt while disabled");

  err_gate_a: assert property (!en_reg[`CRFS_BIT_CSC] && !en_reg[`CRFS_BIT_OVR] |=> !o_err_irq)
    else $error("error interrupt while disabled");

  wake_gate_a: assert property (!en_reg[`CRFS_BIT_WAKE] |=> !o_wake_irq)
    else $error("wake interrupt while disabled");

  en_write_a: assert property (wr_enables |=> en_reg == $past(i_wr_data))
    else $error("enable register write lost");

endmodule

// ==== rtl/crfs_defs.svh ====
// Register offsets, field positions, reset values and thresholds of the receive flag status block
`ifndef CRFS_DEFS_SVH
`define CRFS_DEFS_SVH

// ************************************************
// Register offsets
// ************************************************
`define CRFS_ADDR_W 2
`define CRFS_ADDR_FLAGS 2'h0
`define CRFS_ADDR_ENABLES 2'h1

// ************************************************
// Field positions in both registers
// ************************************************
`define CRFS_BIT_WAKE 7
`define CRFS_BIT_CSC 6
`define CRFS_RECEIVER_STATE_HI 5
`define CRFS_RECEIVER_STATE_LO 4
`define CRFS_TRANSMITTER_STATE_HI 3
`define CRFS_TRANSMITTER_STATE_LO 2
`define CRFS_BIT_OVR 1
`define CRFS_BIT_RXF 0

// ************************************************
// Reset values
// ************************************************
`define CRFS_FLAGS_RST 8'h00
`define CRFS_ENABLES_RST 8'h00

// ************************************************
// Error counter thresholds
// ************************************************
`define CRFS_WARN_LIMIT 96
`define CRFS_ERR_LIMIT 127
`define CRFS_BUSOFF_LIMIT 255

`endif

// ==== rtl/crfs_pkg.sv ====
// Types shared by the receive flag status block
package crfs_pkg;

  // Two-bit bus state code used by both state fields
  typedef enum logic [1:0] {
    CRFS_OK = 2'h0,
    CRFS_WARN = 2'h1,
    CRFS_ERR = 2'h2,
    CRFS_BUSOFF = 2'h3
  } crfs_bus_e;

  // Error counters as delivered by the protocol engine
  typedef struct packed {
    logic [8:0] tx_errors;
    logic [7:0] rx_errors;
  } crfs_cnt_s;

  // Receiver and transmitter state pair
  typedef struct packed {
    crfs_bus_e rx;
    crfs_bus_e tx;
  } crfs_state_s;

endpackage

// ==== rtl/crfs_state_enc.sv ====
// Registered classifier of the error counters into receiver and transmitter bus states
`timescale 1ns/1ps
`include "crfs_defs.svh"

module crfs_state_enc
  import crfs_pkg::*;
#(
  parameter int WARN_LIMIT = `CRFS_WARN_LIMIT,
  parameter int ERR_LIMIT = `CRFS_ERR_LIMIT,
  parameter int BUSOFF_LIMIT = `CRFS_BUSOFF_LIMIT
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Counters in, live state out
  input wire crfs_cnt_s i_counts,
  output crfs_state_s o_live
);

  // ************************************************
  // Classification
  // ************************************************
  crfs_state_s live_next;

  // Bus-off dominates the receiver code as well as the transmitter code
  always_comb begin
    live_next.tx = CRFS_OK;
    live_next.rx = CRFS_OK;
    if (32'(i_counts.tx_errors) > BUSOFF_LIMIT) begin
      live_next.tx = CRFS_BUSOFF;
    end else if (32'(i_counts.tx_errors) > ERR_LIMIT) begin
      live_next.tx = CRFS_ERR;
    end else if (32'(i_counts.tx_errors) > WARN_LIMIT) begin
      live_next.tx = CRFS_WARN;
    end
    if (live_next.tx == CRFS_BUSOFF) begin
      live_next.rx = CRFS_BUSOFF;
    end else if (32'(i_counts.rx_errors) > ERR_LIMIT) begin
      live_next.rx = CRFS_ERR;
    end else if (32'(i_counts.rx_errors) > WARN_LIMIT) begin
      live_next.rx = CRFS_WARN;
    end
  end

  // Live state register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_live <= '{rx: CRFS_OK, tx: CRFS_OK};
    end else begin
      o_live <= live_next;
    end
  end

endmodule

// ==== dv/crfs_msg_src.sv ====
// Receive FIFO source model standing at the far side of the flag block
`timescale 1ns/1ps

module crfs_msg_src (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Bench command and block handshake
  input wire logic i_push,
  input wire logic i_fifo_shift,
  output logic o_fifo_pending
);
  int unsigned queued;

  // Counts queued frames; every push queues one frame and every shift removes one
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      queued <= 0;
    end else begin
      queued <= queued + 32'(i_push) - 32'(i_fifo_shift);
    end
  end

  // Pending stays up while any good frame waits for the foreground buffer
  assign o_fifo_pending = (queued != 0);
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench of the receive flag status block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end

module tb_top;
  import crfs_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [1:0] addr;
  logic [7:0] wd, rdd;
  logic wr, rd, rd_q, ireq, iack, sreq, sack, wen, act, ovr, pend, shift, push, wirq, eirq, rirq;
  crfs_cnt_s cnt;
  logic [15:0] exp_q[$];
  logic [31:0] seed;
  logic [16:0] v;
  logic [16:0] tab[6] = '{{9'd96, 8'd96}, {9'd97, 8'd97}, {9'd127, 8'd127},
    {9'd128, 8'd128}, {9'd255, 8'd255}, {9'd256, 8'd0}};
  int n_mismatch = 0;
  int checked = 0;
  int n_shift = 0;

  crfs_top i_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_wr_data(wd),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdd), .i_init_mode_request(ireq), .i_init_mode_ack(iack),
    .i_sleep_request(sreq), .i_sleep_ack(sack), .i_wake_on_activity_enable(wen),
    .i_bus_activity(act), .i_overrun(ovr), .i_counts(cnt), .i_fifo_pending(pend),
    .o_fifo_shift(shift), .o_wake_irq(wirq), .o_err_irq(eirq), .o_rx_irq(rirq));
  crfs_msg_src i_src (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_push(push),
    .i_fifo_shift(shift), .o_fifo_pending(pend));

  // ************************************************
  // Clock, helpers and result watcher
  // ************************************************
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [1:0] cls(input int c);
    return (c > 255) ? 2'h3 : (c > 127) ? 2'h2 : (c > 96) ? 2'h1 : 2'h0;
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge i_sys_clk);
    wr <= 1'b0;
  endtask

  // Issues a read and notes the masked expectation for the watcher
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_sys_clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge i_sys_clk);
    rd <= 0;
  endtask

  task automatic set_cnt(input logic [16:0] c);
    @(posedge i_sys_clk);
    cnt <= crfs_cnt_s'(c);
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Counts foreground shifts and remembers read cycles
  always @(posedge i_sys_clk) begin
    rd_q <= rd;
    if (shift === 1'b1) n_shift++;
  end

  // Read data stands in the cycle after the strobe; compare it against the oldest note
  always @(negedge i_sys_clk) begin
    logic [15:0] e;
    if (rd_q === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(rdd & e[15:8], e[7:0])
    end
  end

  // Cuts a hang short
  initial begin
    #100us;
    n_mismatch++;
    conclude();
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    {addr, wd, wr, rd, ireq, iack, sreq, sack, wen, act, ovr, push} = '0;
    cnt = '0;
    seed = 32'hd879e427;
    repeat (6) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    reg_rd(0, 8'hff, 8'h00);
    reg_rd(1, 8'hff, 8'h00);
    reg_rd(2, 8'hff, 8'h00);
    // Overrun: masked, then enabled, clear against a fresh event, then a plain clear
    @(posedge i_sys_clk);
    ovr <= 1'b1;
    @(posedge i_sys_clk);
    ovr <= 1'b0;
    step(3);
    `CHK(eirq, 1'b0)
    reg_wr(1, 8'h02);
    step(2);
    `CHK(eirq, 1'b1)
    reg_wr(0, 8'h00);
    reg_rd(0, 8'hff, 8'h02);
    @(posedge i_sys_clk);
    addr <= 2'h0;
    wd <= 8'h02;
    wr <= 1'b1;
    ovr <= 1'b1;
    @(posedge i_sys_clk);
    wr <= 1'b0;
    ovr <= 1'b0;
    reg_rd(0, 8'hff, 8'h02);
    reg_wr(0, 8'h02);
    reg_rd(0, 8'hff, 8'h00);
    // Two frames queued: the second waits until the host releases the buffer
    reg_wr(1, 8'h01);
    @(posedge i_sys_clk);
    push <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    push <= 1'b0;
    step(5);
    `CHK(n_shift, 1)
    `CHK(rirq, 1'b1)
    reg_rd(0, 8'hff, 8'h01);
    reg_wr(0, 8'h01);
    step(4);
    `CHK(n_shift, 2)
    reg_wr(0, 8'h01);
    step(3);
    `CHK(rirq, 1'b0)
    // Wake: activity with request only, then in full sleep
    reg_wr(1, 8'h80);
    @(posedge i_sys_clk);
    sreq <= 1'b1;
    wen <= 1'b1;
    act <= 1'b1;
    reg_rd(0, 8'h80, 8'h00);
    sack <= 1'b1;
    @(posedge i_sys_clk);
    act <= 1'b0;
    step(3);
    `CHK(wirq, 1'b1)
    reg_rd(0, 8'h80, 8'h80);
    sreq <= 1'b0;
    sack <= 1'b0;
    reg_wr(0, 8'h80);
    reg_rd(0, 8'h80, 8'h00);
    // Receiver sensitivity, every code, on a step into the error state
    for (int s = 0; s < 4; s++) begin
      set_cnt(17'h0);
      reg_wr(1, 8'h00);
      reg_wr(0, 8'h40);
      step(3);
      reg_wr(1, {2'b01, 2'(s), 4'h0});
      set_cnt({9'd0, 8'd128});
      step(4);
      reg_rd(0, 8'h70, {1'b0, 1'(s >> 1), 6'h20});
      `CHK(eirq, 1'(s >> 1))
    end
    // Change while the flag pends stays hidden until it is cleared
    set_cnt({9'd0, 8'd97});
    step(4);
    reg_rd(0, 8'h70, 8'h60);
    reg_wr(0, 8'h7c);
    step(3);
    reg_rd(0, 8'h3c, 8'h10);
    // Init mode clears flags and enables but not the state fields
    reg_wr(1, 8'h02);
    @(posedge i_sys_clk);
    ovr <= 1'b1;
    @(posedge i_sys_clk);
    ovr <= 1'b0;
    ireq <= 1'b1;
    iack <= 1'b1;
    step(3);
    reg_rd(0, 8'hff, 8'h10);
    reg_wr(1, 8'h02);
    reg_rd(1, 8'hff, 8'h00);
    ireq <= 1'b0;
    iack <= 1'b0;
    reg_wr(1, 8'h02);
    reg_rd(1, 8'hff, 8'h02);
    reg_wr(0, 8'h40);
    // Counter classification at the boundaries, then random counts
    for (int i = 0; i < 14; i++) begin
      seed = lfsr(seed);
      v = (i < 6) ? tab[i] : seed[16:0];
      set_cnt(v);
      step(4);
      reg_rd(0, 8'h3c, {2'b00, (v[16:8] > 255) ? 2'h3 : cls(int'(v[7:0])), cls(int'(v[16:8])), 2'b00});
    end
    // Transmitter sensitivity on bus-off entry, then the receiver drops straight to ok on the exit
    set_cnt(17'h0);
    step(3);
    reg_wr(1, 8'h44);
    set_cnt({9'd256, 8'd0});
    step(4);
    `CHK(eirq, 1'b1)
    reg_rd(0, 8'h7c, 8'h7c);
    set_cnt({9'd0, 8'd128});
    reg_wr(0, 8'h40);
    reg_rd(0, 8'h7c, 8'h40);
    step(3);
    conclude();
  end
endmodule
